// [hdl/fswe_map.svh]
`ifndef FSWE_MAP_SVH
`define FSWE_MAP_SVH
// Status byte field positions and reset value
`define FSWE_BIT_BUSY 0
`define FSWE_BIT_WEL 1
`define FSWE_BP_LO 2
`define FSWE_BP_HI 5
`define FSWE_BIT_QE 6
`define FSWE_BIT_STATUS_WRITE_DISABLE 7
`define FSWE_STATUS_RST 8'h00
// Ungated opcodes
`define FSWE_OP_WR_ENABLE 8'h06
`define FSWE_OP_WR_DISABLE 8'h04
`define FSWE_OP_RD_STATUS 8'h05
`define FSWE_OP_RD_FUNC 8'h48
`define FSWE_OP_SUSPEND 8'h75
`define FSWE_OP_RESUME 8'h7A
`define FSWE_OP_RST_ENABLE 8'h66
`define FSWE_OP_RST_GO 8'h99
`define FSWE_OP_VOL_RDPARAM 8'hC0
`define FSWE_OP_VOL_BANK 8'h17
// Program opcodes, three and four byte address
`define FSWE_OP_PP3 8'h02
`define FSWE_OP_PP4 8'h12
`define FSWE_OP_PPQ3A 8'h32
`define FSWE_OP_PPQ3B 8'h38
`define FSWE_OP_PPQ4A 8'h34
`define FSWE_OP_PPQ4B 8'h3E
// Sector, block and chip erase opcodes
`define FSWE_OP_SE3A 8'hD7
`define FSWE_OP_SE3B 8'h20
`define FSWE_OP_SE4 8'h21
`define FSWE_OP_BE32_3 8'h52
`define FSWE_OP_BE32_4 8'h5C
`define FSWE_OP_BE64_3 8'hD8
`define FSWE_OP_BE64_4 8'hDC
`define FSWE_OP_CHIP_A 8'hC7
`define FSWE_OP_CHIP_B 8'h60
// Gated register and protection writes
`define FSWE_OP_SR_WRITE 8'h01
`define FSWE_OP_FR_WRITE 8'h42
`define FSWE_OP_RP_NV 8'h65
`define FSWE_OP_RP_V 8'h63
`define FSWE_OP_ERP_NV 8'h85
`define FSWE_OP_ERP_V 8'h83
`define FSWE_OP_IR_ERASE 8'h64
`define FSWE_OP_IR_PROG 8'h62
`define FSWE_OP_BANK_NV 8'h18
`define FSWE_OP_BANK_V 8'hC5
`define FSWE_OP_DYB_A 8'hFB
`define FSWE_OP_DYB_B 8'hE1
`define FSWE_OP_PPB_A 8'hFD
`define FSWE_OP_PPB_B 8'hE3
`define FSWE_OP_PPB_ERASE 8'hE4
`define FSWE_OP_ASP 8'h2F
`define FSWE_OP_PPB_LOCK 8'hA6
`define FSWE_OP_FREEZE 8'h91
`define FSWE_OP_GANG_LOCK 8'h7E
`define FSWE_OP_GANG_UNLOCK 8'h98
`define FSWE_OP_PASSWORD 8'hE8
`define FSWE_OP_DLP_NV 8'h43
`define FSWE_OP_DLP_V 8'h4A
// Frame lengths in bytes, opcode included
`define FSWE_LEN_OP 3'h1
`define FSWE_LEN_DATA 3'h2
`define FSWE_LEN_A3 3'h4
`define FSWE_LEN_A4 3'h5
`define FSWE_IDX_MAX 3'h7
// Block protection geometry, 64 KB blocks in a 128 MB array
`define FSWE_BLK_LSB 16
`define FSWE_BLK_MSB 26
`define FSWE_NUM_BLOCKS 12'h800
`define FSWE_BP12_BLOCKS 12'h600
`define FSWE_BP13_BLOCKS 12'h700
`define FSWE_BP14_BLOCKS 12'h780
`endif

// [hdl/fswe_pkg.sv]
package fswe_pkg;
    // Status byte, most significant field first
    typedef struct packed {
        logic status_write_disable;
        logic quad_enable;
        logic [3:0] protect_bits;
        logic write_enable_latch;
        logic busy_flag;
    } fswe_status_t;
    // One received serial byte
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } fswe_byte_t;
    // Command classes after opcode decode
    typedef enum logic [4:0] {
        CMD_OTHER, CMD_PROG, CMD_ERASE, CMD_CHIP, CMD_SRW, CMD_NVREG,
        CMD_VREG_G, CMD_LOCK, CMD_VOL, CMD_WR_EN, CMD_WR_DIS, CMD_RD_STS,
        CMD_RD_FUN, CMD_SUSP, CMD_RES, CMD_RST_EN, CMD_RST_GO
    } fswe_cmd_t;
    typedef struct packed {
        fswe_cmd_t cmd;
        logic four_byte;
        logic [2:0] need;
    } fswe_decode_t;
    typedef enum logic [1:0] {OP_IDLE, OP_BUSY, OP_SUSP} fswe_op_state_t;
endpackage

// [hdl/fswe_pin_front.sv]
`timescale 1ns/1ps
`default_nettype none
module fswe_pin_front
    import fswe_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_si,
    input wire logic i_wp_n,
    input wire logic i_hw_reset_n,
    output logic o_frame_active,
    output logic o_frame_end,
    output logic o_sck_fall,
    output fswe_byte_t o_byte,
    output logic o_wp_n,
    output logic o_hw_reset
);
    logic [4:0] meta_q;
    logic [4:0] sync_q;
    logic sck_last_q;
    logic cs_n_last_q;
    logic [2:0] bit_cnt_q;
    logic [7:0] shift_q;
    fswe_byte_t byte_q;
    wire sck_s = sync_q[0];
    wire cs_n_s = sync_q[1];
    wire sck_rise = sck_s && !sck_last_q && !cs_n_s;
    wire [7:0] shift_d = {shift_q[6:0], sync_q[2]};

    // Two stage synchroniser for every pin
    always_ff @(posedge i_core_clk) begin
        meta_q <= {i_hw_reset_n, i_wp_n, i_si, i_cs_n, i_sck};
        sync_q <= meta_q;
        sck_last_q <= sck_s;
        cs_n_last_q <= cs_n_s;
    end

    // Mode 0 receive: sample on rising edge, MSB first
    always_ff @(posedge i_core_clk) begin
        if (i_reset || cs_n_s) begin
            bit_cnt_q <= 3'h0;
            shift_q <= 8'h00;
            byte_q <= '0;
        end else begin
            byte_q.valid <= sck_rise && (bit_cnt_q == 3'h7);
            if (sck_rise) begin
                shift_q <= shift_d;
                bit_cnt_q <= bit_cnt_q + 3'h1;
                if (bit_cnt_q == 3'h7) begin
                    byte_q.data <= shift_d;
                end
            end
        end
    end

    // Frame and edge indications
    assign o_frame_active = !cs_n_s;
    assign o_frame_end = cs_n_s && !cs_n_last_q;
    assign o_sck_fall = !sck_s && sck_last_q && !cs_n_s;
    assign o_byte = byte_q;
    assign o_wp_n = sync_q[3];
    assign o_hw_reset = !sync_q[4];
endmodule
`default_nettype wire

// [hdl/fswe_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fswe_map.svh"
module fswe_top
    import fswe_pkg::*;
#(
    parameter int CNT_W = 16,
    parameter int PROG_CYCLES = 200,
    parameter int ERASE_CYCLES = 400,
    parameter int CHIP_CYCLES = 800,
    parameter int REG_CYCLES = 100
) (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_si,
    input wire logic i_wp_n,
    input wire logic i_hw_reset_n,
    output logic o_so,
    output logic o_so_oe_n,
    output fswe_status_t o_status,
    output logic o_quad_enable,
    output logic o_busy
);
    // Opcode decode into class, address width and frame length
    function automatic fswe_decode_t decode_cmd(input logic [7:0] op);
        fswe_decode_t d;
        d = '{cmd: CMD_OTHER, four_byte: 1'b0, need: `FSWE_LEN_OP};
        unique case (op)
            `FSWE_OP_WR_ENABLE: d.cmd = CMD_WR_EN;
            `FSWE_OP_WR_DISABLE: d.cmd = CMD_WR_DIS;
            `FSWE_OP_RD_STATUS: d.cmd = CMD_RD_STS;
            `FSWE_OP_RD_FUNC: d.cmd = CMD_RD_FUN;
            `FSWE_OP_SUSPEND: d.cmd = CMD_SUSP;
            `FSWE_OP_RESUME: d.cmd = CMD_RES;
            `FSWE_OP_RST_ENABLE: d.cmd = CMD_RST_EN;
            `FSWE_OP_RST_GO: d.cmd = CMD_RST_GO;
            `FSWE_OP_CHIP_A, `FSWE_OP_CHIP_B: d.cmd = CMD_CHIP;
            `FSWE_OP_GANG_LOCK, `FSWE_OP_GANG_UNLOCK: d.cmd = CMD_LOCK;
            `FSWE_OP_VOL_RDPARAM, `FSWE_OP_VOL_BANK: begin
                d.cmd = CMD_VOL;
                d.need = `FSWE_LEN_DATA;
            end
            `FSWE_OP_PP3, `FSWE_OP_PPQ3A, `FSWE_OP_PPQ3B: begin
                d.cmd = CMD_PROG;
                d.need = `FSWE_LEN_A3 + 3'h1;
            end
            `FSWE_OP_PP4, `FSWE_OP_PPQ4A, `FSWE_OP_PPQ4B: begin
                d.cmd = CMD_PROG;
                d.four_byte = 1'b1;
                d.need = `FSWE_LEN_A4 + 3'h1;
            end
            `FSWE_OP_SE3A, `FSWE_OP_SE3B, `FSWE_OP_BE32_3,
            `FSWE_OP_BE64_3: begin
                d.cmd = CMD_ERASE;
                d.need = `FSWE_LEN_A3;
            end
            `FSWE_OP_SE4, `FSWE_OP_BE32_4, `FSWE_OP_BE64_4: begin
                d.cmd = CMD_ERASE;
                d.four_byte = 1'b1;
                d.need = `FSWE_LEN_A4;
            end
            `FSWE_OP_SR_WRITE: begin
                d.cmd = CMD_SRW;
                d.need = `FSWE_LEN_DATA;
            end
            `FSWE_OP_FR_WRITE, `FSWE_OP_RP_NV, `FSWE_OP_ERP_NV,
            `FSWE_OP_BANK_NV, `FSWE_OP_IR_ERASE, `FSWE_OP_IR_PROG,
            `FSWE_OP_PPB_A, `FSWE_OP_PPB_B, `FSWE_OP_PPB_ERASE,
            `FSWE_OP_ASP, `FSWE_OP_PPB_LOCK, `FSWE_OP_FREEZE,
            `FSWE_OP_PASSWORD, `FSWE_OP_DLP_NV: begin
                d.cmd = CMD_NVREG;
                d.need = `FSWE_LEN_DATA;
            end
            `FSWE_OP_RP_V, `FSWE_OP_ERP_V, `FSWE_OP_BANK_V,
            `FSWE_OP_DYB_A, `FSWE_OP_DYB_B, `FSWE_OP_DLP_V: begin
                d.cmd = CMD_VREG_G;
                d.need = `FSWE_LEN_DATA;
            end
            default: d.cmd = CMD_OTHER;
        endcase
        return d;
    endfunction

    // Top area protection: is this 64 KB block covered by the setting
    function automatic logic area_protected(input logic [3:0] bp,
                                            input logic [31:0] addr);
        logic [11:0] count;
        logic [11:0] blk;
        count = 12'h000;
        blk = {1'b0, addr[`FSWE_BLK_MSB:`FSWE_BLK_LSB]};
        unique case (bp)
            4'hC: count = `FSWE_BP12_BLOCKS;
            4'hD: count = `FSWE_BP13_BLOCKS;
            4'hE: count = `FSWE_BP14_BLOCKS;
            4'hF: count = `FSWE_NUM_BLOCKS;
            4'h0: count = 12'h000;
            default: count = 12'(12'h001 << (bp - 4'h1));
        endcase
        return (bp != 4'h0) && (blk >= (`FSWE_NUM_BLOCKS - count));
    endfunction

    // Busy time per class, loaded as cycles minus one
    function automatic logic [CNT_W-1:0] op_cycles(input fswe_cmd_t c);
        logic [CNT_W-1:0] n;
        unique case (c)
            CMD_PROG: n = CNT_W'(PROG_CYCLES - 1);
            CMD_ERASE: n = CNT_W'(ERASE_CYCLES - 1);
            CMD_CHIP: n = CNT_W'(CHIP_CYCLES - 1);
            default: n = CNT_W'(REG_CYCLES - 1);
        endcase
        return n;
    endfunction

    logic frame_active;
    logic frame_end;
    logic sck_fall;
    fswe_byte_t rx_byte;
    logic wp_n_s;
    logic hw_reset_s;

    // Pin synchronisers and serial byte receiver
    fswe_pin_front u_front (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_sck(i_sck),
        .i_cs_n(i_cs_n),
        .i_si(i_si),
        .i_wp_n(i_wp_n),
        .i_hw_reset_n(i_hw_reset_n),
        .o_frame_active(frame_active),
        .o_frame_end(frame_end),
        .o_sck_fall(sck_fall),
        .o_byte(rx_byte),
        .o_wp_n(wp_n_s),
        .o_hw_reset(hw_reset_s)
    );

    fswe_op_state_t op_state_q, op_state_d;
    fswe_cmd_t op_kind_q;
    logic [CNT_W-1:0] timer_q, timer_d;
    logic wel_q, wel_d;
    logic status_write_disable_q;
    logic qe_q;
    logic [3:0] bp_q;
    logic [7:0] opcode_q;
    logic [2:0] idx_q;
    logic [31:0] addr_q;
    logic [7:0] sr_data_q;
    logic rst_armed_q;
    logic rd_active_q;
    logic rd_zero_q;
    logic [7:0] tx_sh_q;
    logic [2:0] tx_cnt_q;
    logic so_q;
    fswe_status_t status;

    // Frame decode and acceptance
    wire fswe_decode_t dec = decode_cmd(opcode_q);
    wire is_busy = (op_state_q == OP_BUSY);
    wire is_susp = (op_state_q == OP_SUSP);
    wire complete = frame_end && (idx_q >= dec.need);
    wire susp_ok = (op_kind_q == CMD_PROG) || (op_kind_q == CMD_ERASE) ||
                   (op_kind_q == CMD_CHIP);
    wire busy_pass = (dec.cmd == CMD_RD_STS) || (dec.cmd == CMD_RD_FUN) ||
                     (dec.cmd == CMD_RST_EN) || (dec.cmd == CMD_RST_GO) ||
                     ((dec.cmd == CMD_SUSP) && susp_ok);
    wire accept = complete && (!is_busy || busy_pass);
    wire gated = (dec.cmd == CMD_PROG) || (dec.cmd == CMD_ERASE) ||
                 (dec.cmd == CMD_CHIP) || (dec.cmd == CMD_SRW) ||
                 (dec.cmd == CMD_NVREG) || (dec.cmd == CMD_VREG_G) ||
                 (dec.cmd == CMD_LOCK);
    wire [31:0] target = dec.four_byte ? addr_q : {8'h00, addr_q[23:0]};
    wire prot_hit = ((dec.cmd == CMD_PROG) || (dec.cmd == CMD_ERASE)) &&
                    area_protected(bp_q, target);
    wire chip_block = (dec.cmd == CMD_CHIP) && (bp_q != 4'h0);
    wire sr_locked = (dec.cmd == CMD_SRW) && status_write_disable_q && !wp_n_s;
    wire gate_ok = gated && wel_q && !prot_hit && !chip_block && !sr_locked;
    wire start_op = accept && gate_ok && !is_susp && (dec.cmd != CMD_VREG_G);
    wire sr_commit = start_op && (dec.cmd == CMD_SRW);
    wire wen_go = accept && (dec.cmd == CMD_WR_EN);
    wire wdis_go = accept && (dec.cmd == CMD_WR_DIS);
    wire susp_go = accept && (dec.cmd == CMD_SUSP) && is_busy;
    wire res_go = accept && (dec.cmd == CMD_RES) && is_susp;
    wire rst_go = (accept && (dec.cmd == CMD_RST_GO) && rst_armed_q) ||
                  hw_reset_s;
    wire op_done = is_busy && (timer_q == '0);
    wire addr_len = dec.four_byte;
    wire addr_take = rx_byte.valid && (idx_q != 3'h0) &&
                     (idx_q <= (addr_len ? 3'h4 : 3'h3));

    // Operation sequencer next state
    always_comb begin
        op_state_d = op_state_q;
        timer_d = timer_q;
        unique case (op_state_q)
            OP_IDLE: begin
                if (start_op) begin
                    op_state_d = OP_BUSY;
                    timer_d = op_cycles(dec.cmd);
                end
            end
            OP_BUSY: begin
                if (op_done) begin
                    op_state_d = OP_IDLE;
                end else if (susp_go) begin
                    op_state_d = OP_SUSP;
                end else begin
                    timer_d = timer_q - 1'b1;
                end
            end
            OP_SUSP: begin
                if (res_go) begin
                    op_state_d = OP_BUSY;
                end
            end
        endcase
        if (rst_go) begin
            op_state_d = OP_IDLE;
            timer_d = '0;
        end
    end

    // Latch next value, the set is applied after the disable and completion clears, the reset clear last
    always_comb begin
        wel_d = wel_q;
        if (wdis_go) begin
            wel_d = 1'b0;
        end
        if (op_done) begin
            wel_d = 1'b0;
        end
        if (wen_go) begin
            wel_d = 1'b1;
        end
        if (rst_go) begin
            wel_d = 1'b0;
        end
    end

    // Sequencer and latch registers
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            op_state_q <= OP_IDLE;
            timer_q <= '0;
            op_kind_q <= CMD_OTHER;
            wel_q <= 1'b0;
        end else begin
            op_state_q <= op_state_d;
            timer_q <= timer_d;
            wel_q <= wel_d;
            if (start_op) begin
                op_kind_q <= dec.cmd;
            end
        end
    end

    // Persistent status bits, factory clear
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            status_write_disable_q <= 1'b0;
            qe_q <= 1'b0;
            bp_q <= 4'h0;
        end else if (sr_commit) begin
            status_write_disable_q <= sr_data_q[`FSWE_BIT_STATUS_WRITE_DISABLE];
            qe_q <= sr_data_q[`FSWE_BIT_QE];
            bp_q <= sr_data_q[`FSWE_BP_HI:`FSWE_BP_LO];
        end
    end

    // Frame byte counter, opcode, address and data capture
    always_ff @(posedge i_core_clk) begin
        if (i_reset || frame_end) begin
            idx_q <= 3'h0;
        end else if (rx_byte.valid && (idx_q != `FSWE_IDX_MAX)) begin
            idx_q <= idx_q + 3'h1;
        end
        if (i_reset) begin
            opcode_q <= 8'h00;
            addr_q <= 32'h0000_0000;
            sr_data_q <= 8'h00;
        end else begin
            if (rx_byte.valid && (idx_q == 3'h0)) begin
                opcode_q <= rx_byte.data;
                addr_q <= 32'h0000_0000;
            end
            if (addr_take) begin
                addr_q <= {addr_q[23:0], rx_byte.data};
            end
            if (rx_byte.valid && (idx_q == 3'h1)) begin
                sr_data_q <= rx_byte.data;
            end
        end
    end

    // Reset enable arms, any other accepted command disarms
    always_ff @(posedge i_core_clk) begin
        if (i_reset || rst_go) begin
            rst_armed_q <= 1'b0;
        end else if (accept) begin
            rst_armed_q <= (dec.cmd == CMD_RST_EN);
        end
    end

    assign status.status_write_disable = status_write_disable_q;
    assign status.quad_enable = qe_q;
    assign status.protect_bits = bp_q;
    assign status.write_enable_latch = wel_q;
    assign status.busy_flag = is_busy;

    // Register read: start after opcode, stop at deselect
    always_ff @(posedge i_core_clk) begin
        if (i_reset || !frame_active) begin
            rd_active_q <= 1'b0;
            rd_zero_q <= 1'b0;
        end else if (rx_byte.valid && (idx_q == 3'h0)) begin
            rd_active_q <= (rx_byte.data == `FSWE_OP_RD_STATUS) ||
                           (rx_byte.data == `FSWE_OP_RD_FUNC);
            rd_zero_q <= (rx_byte.data == `FSWE_OP_RD_FUNC);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset || !rd_active_q) begin
            tx_sh_q <= 8'h00;
            tx_cnt_q <= 3'h0;
            so_q <= 1'b0;
        end else if (sck_fall) begin
            tx_cnt_q <= tx_cnt_q + 3'h1;
            if (tx_cnt_q == 3'h0) begin
                so_q <= rd_zero_q ? 1'b0 : status[`FSWE_BIT_STATUS_WRITE_DISABLE];
                tx_sh_q <= rd_zero_q ? 8'h00 : {status[6:0], 1'b0};
            end else begin
                so_q <= tx_sh_q[7];
                tx_sh_q <= {tx_sh_q[6:0], 1'b0};
            end
        end
    end

    // Output pins and status view
    assign o_so = so_q;
    assign o_so_oe_n = !rd_active_q;
    assign o_status = status;
    assign o_quad_enable = qe_q;
    assign o_busy = is_busy;
endmodule
`default_nettype wire

// [sim/fswe_top_props.sv]
`timescale 1ns/1ps
`default_nettype none
module fswe_top_props
    import fswe_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic o_so,
    input wire logic o_so_oe_n,
    input wire fswe_status_t o_status,
    input wire logic o_quad_enable,
    input wire logic o_busy
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    // Port mirrors and reset value
    a_busy_mirror: assert property (o_busy == o_status.busy_flag)
        else $error("busy output differs from status");
    a_quad_mirror: assert property (o_quad_enable == o_status.quad_enable)
        else $error("quad output differs from status");
    a_reset_zero: assert property ($fell(i_reset) |-> o_status == 8'h00)
        else $error("status not clear after reset");
    // Latch gating and busy start
    a_nv_needs_latch: assert property (!$stable(o_status[7:2])
        |-> $past(o_status.write_enable_latch))
        else $error("protect bits changed without latch");
    a_latch_rise_idle: assert property ($rose(o_status.write_enable_latch)
        |-> $past(!o_busy) && $past(i_cs_n, 3))
        else $error("latch set while busy or in frame");
    a_busy_needs_latch: assert property ($rose(o_busy)
        |-> $past(o_status.write_enable_latch) && $past(i_cs_n, 3))
        else $error("busy started without latch");
    a_busy_hold: assert property ($rose(o_busy) |-> o_busy [*4])
        else $error("busy dropped too early");
    // Read data only inside a frame
    a_oe_in_frame: assert property (!o_so_oe_n |-> !$past(i_cs_n, 5))
        else $error("output driven outside a frame");
    a_so_after_fall: assert property (!$stable(o_so) && !o_so_oe_n
        |-> !$past(i_sck, 3))
        else $error("data out changed off a clock fall");
endmodule
bind fswe_top fswe_top_props u_props (.i_core_clk(i_core_clk),
    .i_reset(i_reset), .i_sck(i_sck), .i_cs_n(i_cs_n), .o_so(o_so),
    .o_so_oe_n(o_so_oe_n), .o_status(o_status),
    .o_quad_enable(o_quad_enable), .o_busy(o_busy));
`default_nettype wire

// [sim/fswe_spi_host.sv]
`timescale 1ns/1ps
`default_nettype none
module fswe_spi_host (
    input wire logic i_clk,
    input wire logic i_so,
    output logic o_sck,
    output logic o_cs_n,
    output logic o_si,
    output logic [15:0] o_rd
);
    // Idle bus, clock parked low
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b1;
        o_rd = 16'h0000;
    end
    // Six byte frame, msb first, read bit taken before each fall
    task automatic frame(input logic [47:0] d);
        o_cs_n = 1'b0;
        for (int i = 47; i >= 0; i--) begin
            o_si = d[i];
            repeat (4) @(negedge i_clk);
            o_sck = 1'b1;
            repeat (4) @(negedge i_clk);
            o_rd = {o_rd[14:0], i_so};
            o_sck = 1'b0;
        end
        o_cs_n = 1'b1;
        o_si = ~o_si; // Released line never holds its value
        repeat (8) @(negedge i_clk);
    endtask
endmodule
`default_nettype wire

// [sim/flash_status_write_enable_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module flash_status_write_enable_bench
    import fswe_pkg::*;
;
    logic clk = 1'b0;
    logic rst;
    logic wp_n;
    logic hrst_n;
    logic sck, cs_n, si, so, oe_n, qe, busy;
    logic [15:0] rd;
    fswe_status_t st;
    int n_errors = 0;
    int checks_done = 0;
    logic [7:0] gated [38] = '{8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3E,
        8'hD7, 8'h20, 8'h21, 8'h52, 8'h5C, 8'hD8, 8'hDC, 8'hC7, 8'h60,
        8'h01, 8'h42, 8'h65, 8'h63, 8'h85, 8'h83, 8'h64, 8'h62, 8'h18,
        8'hC5, 8'hFB, 8'hE1, 8'hFD, 8'hE3, 8'hE4, 8'h2F, 8'hA6, 8'h91,
        8'h7E, 8'h98, 8'hE8, 8'h43, 8'h4A};
    fswe_top #(.PROG_CYCLES(600), .ERASE_CYCLES(1000))
        uut (.i_core_clk(clk), .i_reset(rst),
        .i_sck(sck), .i_cs_n(cs_n), .i_si(si), .i_wp_n(wp_n),
        .i_hw_reset_n(hrst_n), .o_so(so), .o_so_oe_n(oe_n), .o_status(st),
        .o_quad_enable(qe), .o_busy(busy));
    fswe_spi_host host (.i_clk(clk), .i_so(so), .o_sck(sck), .o_cs_n(cs_n),
        .o_si(si), .o_rd(rd));
    // Compare tasks
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t status %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t readback %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t pin %b expected %b", $time, got, exp);
        end
    endtask
    // Frame then status, or wait for idle then status
    task automatic op(input logic [47:0] d, input logic [7:0] exp);
        host.frame(d);
        check_byte(st, exp);
    endtask
    task automatic settle(input logic [7:0] exp);
        for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge clk);
        check_byte(st, exp);
    endtask
    task automatic give_verdict();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Clock and watchdog
    initial forever #50 clk = ~clk;
    initial begin
        #4_000_000;
        n_errors++;
        give_verdict();
    end
    // Main sequence
    initial begin
        rst = 1'b1;
        wp_n = 1'b1;
        hrst_n = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        check_byte(st, 8'h00);
        foreach (gated[k]) op({gated[k], 40'hFC_FCFC_FCFC}, 8'h00);
        op(48'h0600_0000_0000, 8'h02);
        op(48'h0400_0000_0000, 8'h00);
        op(48'h0600_0000_0000, 8'h02);
        op(48'h0141_0000_0000, 8'h43);
        settle(8'h40);
        check_bit(qe, 1'b1);
        op(48'h0600_0000_0000, 8'h42);
        host.frame(48'h0500_0000_0000);
        check_word(rd, 16'h4242);
        check_bit(oe_n, 1'b1);
        host.frame(48'h4800_0000_0000);
        check_word(rd, 16'h0000);
        host.frame(48'h0184_0000_0000);
        settle(8'h84);
        check_bit(qe, 1'b0);
        wp_n = 1'b0;
        op(48'h0600_0000_0000, 8'h86);
        op(48'h0100_0000_0000, 8'h86);
        op(48'hC700_0000_0000, 8'h86);
        op(48'h1207_FF00_0000, 8'h86);
        wp_n = 1'b1;
        host.frame(48'h0100_0000_0000);
        settle(8'h00);
        op(48'h0600_0000_0000, 8'h02);
        op(48'h0200_0000_0000, 8'h03);
        op(48'h0400_0000_0000, 8'h03);
        settle(8'h00);
        op(48'h0600_0000_0000, 8'h02);
        op(48'h2000_0000_0000, 8'h03);
        op(48'h7500_0000_0000, 8'h02);
        op(48'h7A00_0000_0000, 8'h03);
        settle(8'h00);
        op(48'h0600_0000_0000, 8'h02);
        op(48'h2000_0000_0000, 8'h03);
        op(48'h6600_0000_0000, 8'h03);
        op(48'h9900_0000_0000, 8'h00);
        op(48'h0600_0000_0000, 8'h02);
        op(48'h0200_0000_0000, 8'h03);
        hrst_n = 1'b0;
        repeat (4) @(negedge clk);
        hrst_n = 1'b1;
        repeat (4) @(negedge clk);
        check_byte(st, 8'h00);
        give_verdict();
    end
endmodule
`default_nettype wire
